// >>> rtl/wfi_edge.v
// Level change detector that reports rising, falling and any edge of one input.
`timescale 1ns/1ps
`default_nettype none

module wfi_edge (
    input wire clk_i,
    input wire rst_n_i,
    input wire level_i,
    output wire rise_o,
    output wire fall_o,
    output wire change_o
);

    reg prev_reg;
    reg armed_reg;

    // Remember the last level; edges are suppressed until one sample has been taken.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            prev_reg <= level_i;
            armed_reg <= 1'b1;
        end
    end

    // Edges compare the present input with the stored level.
    assign rise_o = armed_reg & ~prev_reg & level_i;
    assign fall_o = armed_reg & prev_reg & ~level_i;
    assign change_o = rise_o | fall_o;

endmodule

`default_nettype wire

// >>> rtl/wfi_flag.v
// Sticky flag bank in which a set in the same cycle always wins over a clear.
`timescale 1ns/1ps
`default_nettype none

module wfi_flag #(
    parameter W = 8,
    parameter [W-1:0] MASK = {W{1'b1}}
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [W-1:0] set_i,
    input wire [W-1:0] clr_i,
    output reg [W-1:0] flags_o
);

    // Flags hold until cleared; positions outside the mask never store a one.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            flags_o <= {W{1'b0}};
        end else begin
            flags_o <= ((flags_o & ~clr_i) | set_i) & MASK;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/wfi_regs.vh
// Register offsets, field positions and reset values of the wake and fault interrupt flags.
//
// Behaviour
// - Bit 4 of the flag set goes to 1 whenever the bus failure status changes level.
// - Bit 3 goes to 1 when a falling edge is seen on the local wake input.
// - Bit 2 goes to 1 when a watchdog restart arrives while the watchdog is switched off.
// - Bit 1 is reserved, is never set and always reads 0.
// - Bit 0 goes to 1 when a wake-up over the bus raises an interrupt.
// - Bit 6 goes to 1 when either supply-good indication of the regulated outputs drops.
`ifndef WFI_REGS_VH
`define WFI_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WFI_OFS_FLAGS 5'h00
`define WFI_OFS_CLEAR 5'h04
`define WFI_OFS_ENABLE 5'h08
`define WFI_OFS_LEVELS 5'h0C

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define WFI_BIT_BUS_WAKE 0
`define WFI_BIT_RESERVED 1
`define WFI_BIT_WDOG 2
`define WFI_BIT_LOCAL_WAKE 3
`define WFI_BIT_BUS_FAIL 4
`define WFI_BIT_SUPPLY 6

// ----------------------------------------------------------------
// Widths, masks and reset values
// ----------------------------------------------------------------
`define WFI_FLAG_W 8
`define WFI_FLAG_MASK 8'h5D
`define WFI_FLAG_RST 8'h00
`define WFI_ENABLE_RST 8'h00
`define WFI_RDATA_ZERO 32'h0000_0000

`endif

// >>> rtl/wfi_top.v
// Wake and fault interrupt flag block with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
`include "wfi_regs.vh"

module wfi_top (
    input wire CLK_I,
    input wire RST_N_I,
    // Avalon-MM slave.
    input wire [4:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0] AVS_BYTEENABLE_I,
    output wire [31:0] AVS_READDATA_O,
    output wire AVS_WAITREQUEST_O,
    // Event sources.
    input wire BUS_FAILURE_STATUS_I,
    input wire LOCAL_WAKE_I,
    input wire WDOG_RESTART_I,
    input wire WDOG_OFF_I,
    input wire BUS_WAKE_I,
    input wire PRIMARY_SUPPLY_GOOD_I,
    input wire SWITCHED_SUPPLY_GOOD_I,
    // Interrupt request to the host.
    output wire IRQ_O
);

    // ----------------------------------------------------------------
    // Address decode helper
    // ----------------------------------------------------------------

    // Four registers sit on word boundaries: flag set, clear, enable and live levels.

    // Matches a byte address against a register offset on word boundaries.
    function hit;
        input [4:0] addr;
        input [4:0] ofs;
        begin
            hit = (addr[4:2] == ofs[4:2]);
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg wait_reg;
    reg [31:0] rdata_reg;
    reg [`WFI_FLAG_W-1:0] enable_reg;
    reg [`WFI_FLAG_W-1:0] reported_reg;
    reg irq_reg;
    reg [`WFI_FLAG_W-1:0] set_vec;
    reg [`WFI_FLAG_W-1:0] clr_vec;
    reg [31:0] rdata_next;
    reg [`WFI_FLAG_W-1:0] reported_next;
    wire [`WFI_FLAG_W-1:0] flags;
    wire [`WFI_FLAG_W-1:0] levels;
    wire bus_fail_change;
    wire local_wake_fall;
    wire primary_fall;
    wire switched_fall;
    wire req;
    wire done;
    wire wr_en;
    reg wait_next;
    wire rd_take;
    wire rd_done;
    wire sel_flags;
    wire sel_clear;
    wire sel_enable;
    wire sel_levels;
    wire enable_load;
    wire [`WFI_FLAG_W-1:0] pending;
    wire [`WFI_FLAG_W-1:0] rd_clear;
    wire [`WFI_FLAG_W-1:0] wr_clear;
    wire bus_failure_change_flag_set;
    wire local_wake_edge_flag_set;
    wire watchdog_restart_flag_set;
    wire bus_wake_flag_set;
    wire supply_failure_flag_set;

    // Handshake states, held in the waitrequest flip-flop itself.
    localparam HS_IDLE = 1'b1;
    localparam HS_ANSWER = 1'b0;

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------

    // Any change of the bus failure status is an event.
    wfi_edge u_bus_fail (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .level_i(BUS_FAILURE_STATUS_I),
        .rise_o(),
        .fall_o(),
        .change_o(bus_fail_change)
    );

    // Only a falling edge of the local wake input is an event.
    wfi_edge u_local_wake (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .level_i(LOCAL_WAKE_I),
        .rise_o(),
        .fall_o(local_wake_fall),
        .change_o()
    );

    // Loss of the primary supply-good indication.
    wfi_edge u_primary (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .level_i(PRIMARY_SUPPLY_GOOD_I),
        .rise_o(),
        .fall_o(primary_fall),
        .change_o()
    );

    // Loss of the switched supply-good indication.
    wfi_edge u_switched (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .level_i(SWITCHED_SUPPLY_GOOD_I),
        .rise_o(),
        .fall_o(switched_fall),
        .change_o()
    );

    // Any change of the bus failure status and a falling local wake edge are events.
    assign bus_failure_change_flag_set = bus_fail_change;
    assign local_wake_edge_flag_set = local_wake_fall;

    // A restart only raises its flag while the watchdog is switched off.
    assign watchdog_restart_flag_set = WDOG_RESTART_I & WDOG_OFF_I;

    // A bus wake-up is taken as a level, so a long request sets the flag each cycle.
    assign bus_wake_flag_set = BUS_WAKE_I;

    // Either supply-good indication dropping raises the same supply flag.
    assign supply_failure_flag_set = primary_fall | switched_fall;

    // Gather the event pulses into the flag layout; the reserved slot stays zero.
    always @* begin
        set_vec = `WFI_FLAG_RST;
        set_vec[`WFI_BIT_BUS_FAIL] = bus_failure_change_flag_set;
        set_vec[`WFI_BIT_LOCAL_WAKE] = local_wake_edge_flag_set;
        set_vec[`WFI_BIT_WDOG] = watchdog_restart_flag_set;
        set_vec[`WFI_BIT_RESERVED] = 1'b0;
        set_vec[`WFI_BIT_BUS_WAKE] = bus_wake_flag_set;
        set_vec[`WFI_BIT_SUPPLY] = supply_failure_flag_set;
    end

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------

    // A request is answered one edge after it is first seen.
    assign req = AVS_READ_I | AVS_WRITE_I;
    assign done = req & ~wait_reg;
    assign wr_en = done & AVS_WRITE_I & AVS_BYTEENABLE_I[0];

    // A read is captured on the edge that takes it and completes on the next one.
    assign rd_take = AVS_READ_I & wait_reg;
    assign rd_done = done & AVS_READ_I;

    // Next handshake state: a request seen while idle is answered for exactly one cycle.
    always @* begin
        wait_next = HS_IDLE;
        case (wait_reg)
            HS_IDLE: begin
                if (req) begin
                    wait_next = HS_ANSWER;
                end
            end
            HS_ANSWER: begin
                wait_next = HS_IDLE;
            end
            default: begin
                wait_next = HS_IDLE;
            end
        endcase
    end

    // Waitrequest is the state itself: it idles high and drops for the answer cycle.
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            wait_reg <= HS_IDLE;
        end else begin
            wait_reg <= wait_next;
        end
    end

    // ----------------------------------------------------------------
    // Register select
    // ----------------------------------------------------------------

    // One select per register; the two low byte address bits are ignored.
    assign sel_flags = hit(AVS_ADDRESS_I, `WFI_OFS_FLAGS);
    assign sel_clear = hit(AVS_ADDRESS_I, `WFI_OFS_CLEAR);
    assign sel_enable = hit(AVS_ADDRESS_I, `WFI_OFS_ENABLE);
    assign sel_levels = hit(AVS_ADDRESS_I, `WFI_OFS_LEVELS);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Live view of the event source levels except the watchdog restart and bus wake inputs.
    assign levels = {3'b000, WDOG_OFF_I, SWITCHED_SUPPLY_GOOD_I, PRIMARY_SUPPLY_GOOD_I,
                     LOCAL_WAKE_I, BUS_FAILURE_STATUS_I};

    // Read data is captured while waitrequest is high and stands at the completing edge.
    always @* begin
        rdata_next = `WFI_RDATA_ZERO;
        reported_next = `WFI_FLAG_RST;
        if (rd_take) begin
            if (sel_flags) begin
                rdata_next[`WFI_FLAG_W-1:0] = flags;
                reported_next = flags;
            end else if (sel_enable) begin
                rdata_next[`WFI_FLAG_W-1:0] = enable_reg;
            end else if (sel_levels) begin
                rdata_next[`WFI_FLAG_W-1:0] = levels;
            end else begin
                rdata_next = `WFI_RDATA_ZERO;
            end
        end
    end

    // Hold the captured word and the set of flags it showed to the host.
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rdata_reg <= `WFI_RDATA_ZERO;
            reported_reg <= `WFI_FLAG_RST;
        end else if (rd_take) begin
            rdata_reg <= rdata_next;
            reported_reg <= reported_next;
        end
    end

    assign AVS_READDATA_O = rdata_reg;
    assign AVS_WAITREQUEST_O = wait_reg;

    // ----------------------------------------------------------------
    // Flag clearing
    // ----------------------------------------------------------------

    // A read of the flag set clears only what that read captured and returned.
    assign rd_clear = (rd_done && sel_flags) ? reported_reg : `WFI_FLAG_RST;

    // Ones written to the clear register drop the matching flags.
    assign wr_clear = (wr_en && sel_clear) ? AVS_WRITEDATA_I[`WFI_FLAG_W-1:0] : `WFI_FLAG_RST;

    // Only bits the host has actually seen are cleared by a read, so a flag
    // raised between capture and completion survives until the next read.
    always @* begin
        clr_vec = rd_clear | wr_clear;
    end

    // Sticky flag store; a new event in the clearing cycle keeps its bit set.
    wfi_flag #(
        .W(`WFI_FLAG_W),
        .MASK(`WFI_FLAG_MASK)
    ) u_flags (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .set_i(set_vec),
        .clr_i(clr_vec),
        .flags_o(flags)
    );

    // ----------------------------------------------------------------
    // Enable register and interrupt output
    // ----------------------------------------------------------------

    // Software selects which flags raise the interrupt line.
    assign enable_load = wr_en & sel_enable;

    // The enable register only ever holds bits that name a real flag.
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            enable_reg <= `WFI_ENABLE_RST;
        end else if (enable_load) begin
            enable_reg <= AVS_WRITEDATA_I[`WFI_FLAG_W-1:0] & `WFI_FLAG_MASK;
        end
    end

    // Flags that software has enabled.
    assign pending = flags & enable_reg;

    // Level interrupt, high while any enabled flag is set.
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |pending;
        end
    end

    assign IRQ_O = irq_reg;

endmodule

`default_nettype wire

// >>> tb/test_wake_fault_interrupt_flags.sv
// Self-checking bench of the wake and fault interrupt flag block.
`timescale 1ns/1ps
`default_nettype none

module test_wake_fault_interrupt_flags;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic bfs = 1'b0, lw = 1'b1, wd = 1'b0, off = 1'b1, bw = 1'b0, pg = 1'b1, sg = 1'b1;
    logic rd, wr, wq, irq;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, q;
    int n_fail = 0, checked = 0, cycles = 0;
    int bitpos [6] = '{4, 3, 2, 0, 6, 6};

    wfi_top i_wfi_top (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wq), .BUS_FAILURE_STATUS_I(bfs),
        .LOCAL_WAKE_I(lw), .WDOG_RESTART_I(wd), .WDOG_OFF_I(off), .BUS_WAKE_I(bw),
        .PRIMARY_SUPPLY_GOOD_I(pg), .SWITCHED_SUPPLY_GOOD_I(sg), .IRQ_O(irq));
    wfi_host i_wfi_host (.clk_i(clk), .wait_i(wq), .rdata_i(rdata), .addr_o(addr),
        .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

    // Clock of 8 ns and a cycle ceiling that cuts a hang short.
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
        i_wfi_host.xfer(1'b0, a, 32'h0000_0000, q);
        chk(what, exp, q);
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        i_wfi_host.xfer(1'b1, a, d, q);
    endtask

    // Raise event k for one cycle, then put the line back to its idle level; event 0 toggles the bus failure status and leaves it there.
    task automatic ev(input int k);
        @(posedge clk);
        case (k)
            0: bfs <= ~bfs;
            1: lw <= 1'b0;
            2: wd <= 1'b1;
            3: bw <= 1'b1;
            4: pg <= 1'b0;
            default: sg <= 1'b0;
        endcase
        @(posedge clk);
        {lw, wd, bw, pg, sg} <= 5'h13;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        rd_chk("flags", 5'h00, 32'h0000_0000);
        rd_chk("enable", 5'h08, 32'h0000_0000);
        rd_chk("clear", 5'h04, 32'h0000_0000);
        rd_chk("unmapped", 5'h10, 32'h0000_0000);
        rd_chk("levels", 5'h0C, 32'h0000_001E);
    endtask

    // Each source sets its bit (both supply indications share bit 6), and reading the flags clears it.
    task automatic t_events();
        for (int k = 0; k < 6; k++) begin
            ev(k);
            rd_chk("event flag", 5'h00, 32'h0000_0001 << bitpos[k]);
            rd_chk("flag after read", 5'h00, 32'h0000_0000);
        end
    endtask

    task automatic t_wdog_on();
        @(posedge clk);
        off <= 1'b0;
        ev(2);
        rd_chk("restart while on", 5'h00, 32'h0000_0000);
        off <= 1'b1;
    endtask

    task automatic t_sticky();
        ev(3);
        repeat (30) @(posedge clk);
        ev(1);
        rd_chk("held flags", 5'h00, 32'h0000_0009);
        bw <= 1'b1;
        rd_chk("set during clear", 5'h00, 32'h0000_0001);
        rd_chk("set wins clear", 5'h00, 32'h0000_0001);
        bw <= 1'b0;
        rd_chk("last set kept", 5'h00, 32'h0000_0001);
        rd_chk("kept flag cleared", 5'h00, 32'h0000_0000);
    endtask

    task automatic t_irq();
        wr_reg(5'h08, 32'h0000_00FF);
        rd_chk("enable mask", 5'h08, 32'h0000_005D);
        ev(2);
        @(negedge clk);
        chk("irq set", 32'h0000_0001, {31'h0, irq});
        wr_reg(5'h04, 32'h0000_0004);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        wr_reg(5'h08, 32'h0000_0000);
        ev(0);
        @(negedge clk);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        rd_chk("masked flag", 5'h00, 32'h0000_0010);
    endtask

    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_events();
        t_wdog_on();
        t_sticky();
        t_irq();
        final_report();
    end
endmodule

bind wfi_top wfi_monitor i_wfi_monitor (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .IRQ_O(IRQ_O));

`default_nettype wire

// >>> tb/wfi_host.sv
// Host model that issues single Avalon-MM transfers to the flag block.
`timescale 1ns/1ps
`default_nettype none

module wfi_host (
    input wire logic clk_i,
    input wire logic wait_i,
    input wire logic [31:0] rdata_i,
    output logic [4:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [31:0] wdata_o
);
    // Idle bus at time zero.
    initial begin
        addr_o = 5'h00;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 32'h0000_0000;
    end

    // One transfer: hold everything until ready is sampled, then release.
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= ~w;
        wr_o <= w;
        wdata_o <= d;
        do @(posedge clk_i); while (wait_i !== 1'b0);
        q = rdata_i;
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        addr_o <= ~a; // Released lines show a changed value.
        wdata_o <= ~d;
    endtask
endmodule

`default_nettype wire

// >>> tb/wfi_monitor.sv
// Concurrent checks on the ports of the wake and fault flag block.
`timescale 1ns/1ps
`default_nettype none

module wfi_monitor (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [4:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic IRQ_O
);
    // ------------------------------------------------------------
    // Bus handshake, reserved bits and interrupt hold.
    // ------------------------------------------------------------
    wait_one_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("taken request got no ready cycle");
    wait_pulse_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O) else $error("ready held too long");
    wait_idle_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !(AVS_READ_I || AVS_WRITE_I) |=> AVS_WAITREQUEST_O) else $error("ready without request");
    irq_reset_a: assert property (@(posedge CLK_I) !RST_N_I |=> !IRQ_O && AVS_WAITREQUEST_O
        && AVS_READDATA_O == 32'h0000_0000) else $error("outputs not cleared by reset");
    sticky_irq_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        IRQ_O && !(AVS_READ_I || AVS_WRITE_I || $past(AVS_READ_I) || $past(AVS_WRITE_I))
        |=> IRQ_O) else $error("interrupt dropped without host access");
    rsvd_bit_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[4:2] == 3'h0 |-> !AVS_READDATA_O[1])
        else $error("reserved flag bit read as one");
    upper_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        AVS_READDATA_O[31:8] == 24'h00_0000) else $error("upper read data not zero");
    rdata_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !(AVS_READ_I && AVS_WAITREQUEST_O) |=> $stable(AVS_READDATA_O))
        else $error("read data changed without capture");
    // Main scenarios reached.
    read_done_c: cover property (@(posedge CLK_I) AVS_READ_I && !AVS_WAITREQUEST_O);
    write_done_c: cover property (@(posedge CLK_I) AVS_WRITE_I && !AVS_WAITREQUEST_O);
    irq_rise_c: cover property (@(posedge CLK_I) $rose(IRQ_O));
endmodule

`default_nettype wire
